/* File: etsr_sample_readout.v */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - Sample 8 bit 30: 1 rising, 0 falling
// - Sample 8 nanoseconds in bits 29:0
// - Sample 8 seconds 32 bits, reset zero
// - Phase bits 2:0 give 8ns slot
// - Third slot code taken as 101
// - Unit pointer bit 8 selects unit
// - Sample 7 has own phase field
// - Sample 7 edge, ns, seconds alike
`include "etsr_regs.vh"
// Register map, one aligned 32-bit word each
//   0x59C  sample 7 edge and nanoseconds, per unit
//   0x5A0  sample 7 seconds, per unit
//   0x5A4  sample 7 phase code
//   0x5A8  sample 8 edge and nanoseconds, per unit
//   0x5AC  sample 8 seconds, per unit
//   0x5B0  sample 8 phase code
//   0x500  unit index, pointer in bit 8
// Every other word answers SLVERR and reads zero.
// Limitation: only two units, so the pointer is a single bit;
// a wider pointer needs wider storage arrays and a wider field.
// Bus timing: a request taken at one edge is answered at the next,
// and the answer stands until the master takes it.

// Reset: all samples zero, phase codes 000, unit pointer 0, both
// answers idle. The first request may follow the first edge after
// reset is released.
// Ordering: one write and one read may be under way at a time, and
// they do not wait for each other. A capture and a read of the same
// word in one cycle answer the old value; the read after sees the new.
// Phase slots: 0, 8, 16, 24 and 32ns inside the 40ns period map to
// codes 000, 001, 101, 011 and 100. The third slot shares its code
// with the reserved range, so it must be confirmed before tape-out;
// slot numbers above four clamp to the last slot rather than emit a
// reserved code.
module etsr_sample_readout #(
  parameter ADDR_W = 12
) (
  input  wire              sys_clk,         // 250 MHz clock
  input  wire              resetn,          // Async reset, active low
  // Capture engine, two timestamp units, same clock
  input  wire              capValid,        // Pulse: new capture for sample slot
  input  wire              capUnit,         // Unit index of the capture
  input  wire              capSlot8,        // 1 = eighth sample, 0 = seventh
  input  wire              capRising,       // Edge polarity of the event
  input  wire [29:0]       capNanosec,      // Nanoseconds low word
  input  wire [31:0]       capSeconds,      // Seconds value
  input  wire [2:0]        capSlotIdx,      // 8ns slot number 0..4 in 40ns
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,    // Write address
  input  wire              s_axi_awvalid,   // Write address valid
  output wire              s_axi_awready,   // Write address ready
  input  wire [31:0]       s_axi_wdata,     // Write data
  input  wire [3:0]        s_axi_wstrb,     // Write strobes
  input  wire              s_axi_wvalid,    // Write data valid
  output wire              s_axi_wready,    // Write data ready
  output reg  [1:0]        s_axi_bresp,     // Write response
  output reg               s_axi_bvalid,    // Write response valid
  input  wire              s_axi_bready,    // Write response ready
  input  wire [ADDR_W-1:0] s_axi_araddr,    // Read address
  input  wire              s_axi_arvalid,   // Read address valid
  output wire              s_axi_arready,   // Read address ready
  output reg  [31:0]       s_axi_rdata,     // Read data
  output reg  [1:0]        s_axi_rresp,     // Read response
  output reg               s_axi_rvalid,    // Read data valid
  input  wire              s_axi_rready     // Read data ready
);

  // Word indices of the register map; the two low address bits are
  // dropped because every register is one aligned word
  localparam WORD_W = ADDR_W - 2;
  localparam [ADDR_W-1:0] S7_NS_A  = `ETSR_S7_NS_ADDR;
  localparam [ADDR_W-1:0] S7_SEC_A = `ETSR_S7_SEC_ADDR;
  localparam [ADDR_W-1:0] S7_PH_A  = `ETSR_S7_PH_ADDR;
  localparam [ADDR_W-1:0] S8_NS_A  = `ETSR_S8_NS_ADDR;
  localparam [ADDR_W-1:0] S8_SEC_A = `ETSR_S8_SEC_ADDR;
  localparam [ADDR_W-1:0] S8_PH_A  = `ETSR_S8_PH_ADDR;
  localparam [ADDR_W-1:0] UNIT_A   = `ETSR_UNIT_IDX_ADDR;
  localparam [WORD_W-1:0] S7_NS_W  = S7_NS_A[ADDR_W-1:2];
  localparam [WORD_W-1:0] S7_SEC_W = S7_SEC_A[ADDR_W-1:2];
  localparam [WORD_W-1:0] S7_PH_W  = S7_PH_A[ADDR_W-1:2];
  localparam [WORD_W-1:0] S8_NS_W  = S8_NS_A[ADDR_W-1:2];
  localparam [WORD_W-1:0] S8_SEC_W = S8_SEC_A[ADDR_W-1:2];
  localparam [WORD_W-1:0] S8_PH_W  = S8_PH_A[ADDR_W-1:2];
  localparam [WORD_W-1:0] UNIT_W   = UNIT_A[ADDR_W-1:2];
  // Byte lane that carries the pointer bit
  localparam PTR_LANE = `ETSR_UNIT_PTR_BIT / 8;
  // Units kept per sample; the pointer is one bit
  localparam UNITS = 2;

  // Word index of a byte address, shared by both channels
  function [WORD_W-1:0] wordOf;
    input [ADDR_W-1:0] addr;
    begin
      wordOf = addr[ADDR_W-1:2];
    end
  endfunction

  // Nanoseconds word: edge flag above a 30-bit count, bit 31 zero
  function [31:0] packNs;
    input        edgeUp;
    input [29:0] ns;
    begin
      packNs                 = `ETSR_ZERO32;
      packNs[`ETSR_EDGE_BIT] = edgeUp;
      packNs[`ETSR_NS_MSB:0] = ns;
    end
  endfunction

  // Phase word: code in the low bits, reserved bits zero
  function [31:0] packPh;
    input [2:0] code;
    begin
      packPh                 = `ETSR_ZERO32;
      packPh[`ETSR_PH_MSB:0] = code;
    end
  endfunction

  // Bus answer code for a decoded or refused access
  function [1:0] respOf;
    input ok;
    begin
      respOf = ok ? `ETSR_RESP_OKAY : `ETSR_RESP_SLVERR;
    end
  endfunction

  // Slot number to documented phase code; out-of-range clamps to last slot
  function [2:0] slotCode;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    slotCode = `ETSR_SLOT_0NS;
        3'h1:    slotCode = `ETSR_SLOT_8NS;
        3'h2:    slotCode = `ETSR_SLOT_16NS;
        3'h3:    slotCode = `ETSR_SLOT_24NS;
        default: slotCode = `ETSR_SLOT_32NS;  // Never 110/111
      endcase
    end
  endfunction

  // Storage, index = unit; phase codes and unit pointer are single registers
  reg        edge7_r [0:1];
  reg [29:0] ns7_r   [0:1];
  reg [31:0] sec7_r  [0:1];
  reg [2:0]  ph7_r;
  reg        edge8_r [0:1];
  reg [29:0] ns8_r   [0:1];
  reg [31:0] sec8_r  [0:1];
  reg [2:0]  ph8_r;
  reg        unitPtr_r;
  integer    i;

  integer    j;

  // Capture decode. The capture engine runs on this clock, so its
  // fields are used as they come, with no synchroniser.
  // Each capture loads a whole word at one edge, so a read never
  // sees half of an old sample and half of a new one.
  // Slot numbers are coded once here and shared by both samples.
  wire       cap7Go  = capValid && !capSlot8;
  wire       cap8Go  = capValid &&  capSlot8;
  wire [2:0] capCode = slotCode(capSlotIdx);

  // Eighth sample edge, nanoseconds and seconds, kept per unit
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < UNITS; i = i + 1) begin
        edge8_r[i] <= 1'b0;
        ns8_r[i]   <= 30'h00000000;
        sec8_r[i]  <= `ETSR_ZERO32;
      end
    end else if (cap8Go) begin
      edge8_r[capUnit] <= capRising;
      ns8_r[capUnit]   <= capNanosec;
      sec8_r[capUnit]  <= capSeconds;
    end
  end

  // Seventh sample, same layout as the eighth. Kept in its own
  // process with its own loop index so neither shares a driver.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (j = 0; j < UNITS; j = j + 1) begin
        edge7_r[j] <= 1'b0;
        ns7_r[j]   <= 30'h00000000;
        sec7_r[j]  <= `ETSR_ZERO32;
      end
    end else if (cap7Go) begin
      edge7_r[capUnit] <= capRising;
      ns7_r[capUnit]   <= capNanosec;
      sec7_r[capUnit]  <= capSeconds;
    end
  end

  // Phase codes. One per sample, shared by both units: a capture on
  // either unit overwrites it, so software reads it before the next
  // capture of the same sample. Reset shows the 0ns slot.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ph7_r <= `ETSR_SLOT_0NS;
      ph8_r <= `ETSR_SLOT_0NS;
    end else begin
      if (cap7Go)
        ph7_r <= capCode;
      if (cap8Go)
        ph8_r <= capCode;
    end
  end

  // Values seen through the unit pointer. Phase words ignore the
  // pointer since they are not kept per unit.
  wire        edge7View = edge7_r[unitPtr_r];
  wire [29:0] ns7View   = ns7_r[unitPtr_r];
  wire [31:0] sec7View  = sec7_r[unitPtr_r];
  wire        edge8View = edge8_r[unitPtr_r];
  wire [29:0] ns8View   = ns8_r[unitPtr_r];
  wire [31:0] sec8View  = sec8_r[unitPtr_r];

  // Write channel. Address and data are taken together, which keeps
  // them paired without holding registers; a master that offers one
  // alone waits until it offers the other. A new write is held off
  // while the previous answer is still pending.
  // Only the unit index word is writable; sample words refuse writes
  // with SLVERR and keep their contents.
  wire wrGo     = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire wrHit    = (wordOf(s_axi_awaddr) == UNIT_W);
  wire ptrWrite = wrGo && wrHit && s_axi_wstrb[PTR_LANE];
  assign s_axi_awready = wrGo;
  assign s_axi_wready  = wrGo;

  // Write answer, one cycle after the request is taken; it stands
  // until the master shows bready
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ETSR_RESP_OKAY;
    end else if (wrGo) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= respOf(wrHit);
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Unit pointer; a write that leaves the pointer's byte lane
  // disabled is answered OKAY but changes nothing
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      unitPtr_r <= 1'b0;
    end else if (ptrWrite) begin
      unitPtr_r <= s_axi_wdata[`ETSR_UNIT_PTR_BIT];
    end
  end

  // Read decode. A pure mux, so a read changes nothing every
  // bit outside a defined field reads zero, and an unmapped word
  // reads zero with SLVERR.
  reg [31:0] rdVal;
  reg        rdOk;
  always @* begin
    rdVal = `ETSR_ZERO32;
    rdOk  = 1'b1;
    case (wordOf(s_axi_araddr))
      S7_NS_W:  rdVal = packNs(edge7View, ns7View);
      S7_SEC_W: rdVal = sec7View;
      S7_PH_W:  rdVal = packPh(ph7_r);
      S8_NS_W:  rdVal = packNs(edge8View, ns8View);
      S8_SEC_W: rdVal = sec8View;
      S8_PH_W:  rdVal = packPh(ph8_r);
      UNIT_W:   rdVal[`ETSR_UNIT_PTR_BIT] = unitPtr_r;
      default:  rdOk = 1'b0;
    endcase
  end

  // Read channel. One read at a time: the address is refused while
  // data is pending. The word is sampled when the address is taken,
  // so a capture in the next cycle does not change the answer.
  // Data and response stand until the master shows rready.
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `ETSR_ZERO32;
      s_axi_rresp  <= `ETSR_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdVal;
      s_axi_rresp  <= respOf(rdOk);
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // etsr_sample_readout

/* File: etsr_regs.vh */
`ifndef ETSR_REGS_VH
`define ETSR_REGS_VH
// Byte addresses of the sample registers and the unit index
`define ETSR_S7_NS_ADDR    12'h59C
`define ETSR_S7_SEC_ADDR   12'h5A0
`define ETSR_S7_PH_ADDR    12'h5A4
`define ETSR_S8_NS_ADDR    12'h5A8
`define ETSR_S8_SEC_ADDR   12'h5AC
`define ETSR_S8_PH_ADDR    12'h5B0
`define ETSR_UNIT_IDX_ADDR 12'h500
// Field positions
`define ETSR_EDGE_BIT      30
`define ETSR_NS_MSB        29
`define ETSR_PH_MSB        2
`define ETSR_UNIT_PTR_BIT  8
// Phase slot codes
`define ETSR_SLOT_0NS      3'h0
`define ETSR_SLOT_8NS      3'h1
`define ETSR_SLOT_16NS     3'h5
`define ETSR_SLOT_24NS     3'h3
`define ETSR_SLOT_32NS     3'h4
// Reset values and bus answers
`define ETSR_ZERO32        32'h00000000
`define ETSR_RESP_OKAY     2'h0
`define ETSR_RESP_SLVERR   2'h2
`endif

/* File: etsr_chk.sv */
`timescale 1ns/1ps
// Bus answers and read-back field checks
module etsr_chk #(parameter ADDR_W = 12) (
  input wire logic sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, // Clock, write
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_rvalid, s_axi_rready, // Hs
  input wire logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr, // Addresses
  input wire logic [1:0] s_axi_bresp, s_axi_rresp, // Responses
  input wire logic [31:0] s_axi_rdata // Read data
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Taken requests; read address kept since the bus moves on
  wire wrTake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rdTake = s_axi_arvalid && !s_axi_rvalid;
  logic [ADDR_W-1:0] rdAddr_r;
  always @(posedge sys_clk) if (rdTake) rdAddr_r <= s_axi_araddr;
  chk_wr_answer: assert property
    (wrTake |=> s_axi_bvalid) else $error("write not answered");
  chk_wr_refused: assert property
    (wrTake && s_axi_awaddr[ADDR_W-1:2] != 10'h140 |=> s_axi_bresp == 2'h2)
    else $error("write not refused");
  chk_wr_once: assert property
    (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
  chk_rd_answer: assert property
    (rdTake |=> s_axi_rvalid) else $error("read not answered");
  chk_rd_once: assert property
    (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
  chk_phase_code: assert property (s_axi_rvalid &&
    (rdAddr_r == 12'h5A4 || rdAddr_r == 12'h5B0) |-> s_axi_rdata < 32'h6) else $error("bad phase");
  chk_ns_top_bit: assert property (s_axi_rvalid &&
    (rdAddr_r == 12'h59C || rdAddr_r == 12'h5A8) |-> !s_axi_rdata[31]) else $error("bit 31 set");
  chk_rd_unmapped: assert property (s_axi_rvalid && rdAddr_r[ADDR_W-1:2] != 10'h140 &&
    (rdAddr_r[ADDR_W-1:2] < 10'h167 || rdAddr_r[ADDR_W-1:2] > 10'h16C)
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  // Main traffic seen
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // etsr_chk
bind etsr_sample_readout etsr_chk #(.ADDR_W(ADDR_W)) chk (.*);

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "etsr_regs.vh"
module tb_top;
  logic sys_clk = 0, resetn = 0, capValid = 0, capUnit = 0, capSlot8 = 0, capRising = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
  logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [29:0] capNanosec = 0;
  logic [31:0] capSeconds = 0, s_axi_wdata = 0, s_axi_rdata;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] capSlotIdx = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] code [8] = '{3'h0, 3'h1, 3'h5, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
  int error_cnt = 0, compares = 0;
  etsr_sample_readout uut (.*);
  initial forever #2 sys_clk = ~sys_clk;
  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ready is judged at the falling edge, so no race with the launching edge
  function automatic logic rdy(input int sel);
    case (sel)
      0: return s_axi_awready;
      1: return s_axi_bvalid;
      2: return s_axi_arready;
      default: return s_axi_rvalid;
    endcase
  endfunction
  task automatic hs(input int sel);
    int n = 0;
    do @(negedge sys_clk); while (rdy(sel) !== 1'b1 && ++n < 99);
    if (n >= 99) begin
      error_cnt++;
      print_verdict;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    hs(0);
    @(posedge sys_clk);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    hs(1);
    chk({30'h0, s_axi_bresp}, e);
    @(posedge sys_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, re);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    hs(2);
    @(posedge sys_clk);
    s_axi_arvalid <= 0;
    hs(3);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, re);
    @(posedge sys_clk);
  endtask
  // Second edge keeps capValid from being set twice in one step
  task cap(input logic u, s8, r, input logic [29:0] ns, input logic [31:0] s, input logic [2:0] i);
    {capUnit, capSlot8, capRising, capNanosec, capSeconds, capSlotIdx} <= {u, s8, r, ns, s, i};
    capValid <= 1;
    @(posedge sys_clk);
    capValid <= 0;
    @(posedge sys_clk);
  endtask
  task print_verdict;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1;
    rd(`ETSR_S8_SEC_ADDR, 0, 0);
    $display("test 1 done");
    for (int i = 0; i < 8; i++) begin
      cap(0, 1, i[0], 30'(i), 32'(i), 3'(i));
      cap(0, 0, !i[0], 30'(i), 32'(i), 3'(7 - i));
      rd(`ETSR_S8_PH_ADDR, 32'(code[i]), 0);
      rd(`ETSR_S7_PH_ADDR, 32'(code[7 - i]), 0);
      rd(`ETSR_S7_NS_ADDR, {1'b0, !i[0], 30'(i)}, 0);
      rd(`ETSR_S7_SEC_ADDR, 32'(i), 0);
      rd(`ETSR_S8_NS_ADDR, {1'b0, i[0], 30'(i)}, 0);
    end
    $display("test 2 done");
    cap(1, 1, 1, 30'h5, 32'hA5A5A5A5, 0);
    rd(`ETSR_S8_SEC_ADDR, 32'h7, 0);
    wr(`ETSR_UNIT_IDX_ADDR, 32'h100, 0);
    rd(`ETSR_S8_SEC_ADDR, 32'hA5A5A5A5, 0);
    rd(`ETSR_S8_NS_ADDR, 32'h40000005, 0);
    rd(`ETSR_UNIT_IDX_ADDR, 32'h100, 0);
    rd(`ETSR_S7_SEC_ADDR, 0, 0);
    wr(`ETSR_UNIT_IDX_ADDR, 0, 0);
    $display("test 3 done");
    wr(`ETSR_S8_SEC_ADDR, 32'h1234, 2);
    rd(`ETSR_S8_SEC_ADDR, 32'h7, 0);
    rd(12'h0F0, 0, 2);
    $display("test 4 done");
    print_verdict;
  end
endmodule // tb_top
